// >>> test/adc_front_end_model.sv
/*
 * analog front end model: sixteen fixed input levels, a multiplexer and a comparator.
 * assumes registered select and trial code from the block and levels from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_front_end_model (
	// input levels, ten bits per input
	input wire logic [159:0] levels_i,
	// block side
	input wire adc_ctrl_pkg::input_select_t input_select_i,
	input wire adc_ctrl_pkg::result_t trial_code_i,
	input wire logic power_on_i,
	// comparator
	output logic compare_o
);
	import adc_ctrl_pkg::*;
	result_t level;
	// ------------------------------------------------------------------
	// comparator
	// ------------------------------------------------------------------
	// powered down it gives trial code bit 0, which the block holds at zero while off, so the decision stays low
	always_comb begin
		level = levels_i[input_select_i * 10 +: 10];
		compare_o = power_on_i ? (level >= trial_code_i) : trial_code_i[0];
	end
endmodule
`default_nettype wire

// >>> test/adc_sequencer_control_tb.sv
/*
 * bench of the converter control block: one row per input, then hand cases.
 * assumes the front end model and a classic wishbone master in this module.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_sequencer_control_tb;
	import adc_ctrl_pkg::*;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, wait_mode_i, halt_mode_i, compare_i;
	logic ack_o, err_o, sample_o, power_on_o, e;
	logic [9:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic [159:0] levels;
	input_select_t input_select_o;
	result_t trial_code_o;
	result_t lv [16];
	int fails, check_count, n;
	time t0;
	adc_sequencer_control adc_sequencer_control_i (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.wait_mode_i(wait_mode_i), .halt_mode_i(halt_mode_i), .compare_i(compare_i),
		.input_select_o(input_select_o), .sample_o(sample_o), .power_on_o(power_on_o),
		.trial_code_o(trial_code_o));
	adc_front_end_model adc_front_end_model_i (.levels_i(levels),
		.input_select_i(input_select_o), .trial_code_i(trial_code_o),
		.power_on_i(power_on_o), .compare_o(compare_i));
	always_comb begin
		for (int k = 0; k < 16; k++) levels[k * 10 +: 10] = lv[k];
	end
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task results();
		if (fails == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until the edge that sees ack or err
	task wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1 && err_o !== 1'b1) @(posedge clk_i);
		q = dat_o;
		e = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task poll();
		n = 0;
		q = 32'h0;
		while (q[7] !== 1'b1 && n < 300) begin
			wb(1'b0, `ADDR_CONTROL_STATUS, 8'h00);
			n++;
		end
		cmp({31'h0, q[7]}, 32'h1);
	endtask
	// ------------------------------------------------------------------
	// clock, watchdog, sequence
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		results();
	end
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 10'h0;
		sel_i = 4'h1;
		dat_i = 32'h0;
		wait_mode_i = 1'b1;
		halt_mode_i = 1'b0;
		lv = '{10'h000, 10'h3ff, 10'h155, 10'h2aa, 10'h001, 10'h200, 10'h1ff, 10'h3fe,
			10'h0f0, 10'h30f, 10'h081, 10'h17e, 10'h240, 10'h002, 10'h3c3, 10'h123};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 3; a++) begin
			wb(1'b0, `ADDR_CONTROL_STATUS + 10'(a * 4), 8'h00);
			cmp(q, 32'h0); // reset value
		end
		// rows: input index and speed in, level out; wait mode held high meanwhile
		for (int c = 0; c < 16; c++) begin
			wb(1'b1, `ADDR_CONTROL_STATUS, {1'b1, c[0], 2'b10, c[3:0]});
			wb(1'b0, `ADDR_CONTROL_STATUS, 8'h00);
			cmp(q, {24'h0, 1'b0, c[0], 2'b10, c[3:0]});
			cmp({27'h0, power_on_o, input_select_o}, {28'h1, c[3:0]});
			@(posedge sample_o);
			t0 = $time;
			@(posedge sample_o);
			cmp(32'((($time - t0) / 8)), c[0] ? 32'd24 : 32'd48);
			poll();
			wb(1'b0, `ADDR_RESULT_LOW, 8'h00);
			cmp(q, {30'h0, lv[c][1:0]});
			wb(1'b0, `ADDR_RESULT_HIGH, 8'h00);
			cmp(q, {24'h0, lv[c][9:2]});
			wb(1'b0, `ADDR_CONTROL_STATUS, 8'h00);
			cmp({31'h0, q[7]}, 32'h0); // cleared by high read
		end
		// a write without lane 0 must leave the register alone
		sel_i <= 4'h2;
		wb(1'b1, `ADDR_CONTROL_STATUS, 8'h00);
		sel_i <= 4'h1;
		wb(1'b0, `ADDR_CONTROL_STATUS, 8'h00);
		cmp({25'h0, q[6:0]}, 32'h6f); // lane 0 not selected
		wait_mode_i <= 1'b0;
		wb(1'b1, `ADDR_RESULT_HIGH, 8'h5a);
		wb(1'b0, `ADDR_RESULT_HIGH, 8'h00);
		cmp(q, {24'h0, lv[15][9:2]}); // read-only
		wb(1'b0, 10'h1cc, 8'h00);
		cmp({31'h0, e}, 32'h1); // unmapped address
		// input change in mid-conversion, then an 8-bit read
		wb(1'b1, `ADDR_CONTROL_STATUS, 8'h23);
		repeat (12) @(posedge clk_i);
		wb(1'b1, `ADDR_CONTROL_STATUS, 8'h25);
		wb(1'b0, `ADDR_CONTROL_STATUS, 8'h00);
		cmp({31'h0, q[7]}, 32'h0);
		poll();
		wb(1'b0, `ADDR_RESULT_HIGH, 8'h00);
		cmp(q, {24'h0, lv[5][9:2]});
		// converter off: no conversion may finish
		wb(1'b1, `ADDR_CONTROL_STATUS, 8'h05);
		repeat (200) @(posedge clk_i);
		wb(1'b0, `ADDR_CONTROL_STATUS, 8'h00);
		cmp({22'h0, power_on_o, sample_o, q[7:0]}, 32'h05);
		// halt stops it, settle flag gates use after wakeup
		wb(1'b1, `ADDR_CONTROL_STATUS, 8'h21);
		halt_mode_i <= 1'b1;
		wb(1'b1, `ADDR_CONTROL_STATUS, 8'h21);
		repeat (200) @(posedge clk_i);
		wb(1'b0, `ADDR_CONTROL_STATUS, 8'h00);
		cmp({22'h0, power_on_o, q[8:0]}, 32'h21);
		wb(1'b0, `ADDR_POWER_MODE, 8'h00);
		cmp(q, 32'h0); // not settled while halted
		halt_mode_i <= 1'b0;
		n = 0;
		q = 32'h0;
		while (q[0] !== 1'b1 && n < 200) begin
			wb(1'b0, `ADDR_POWER_MODE, 8'h00);
			n++;
		end
		cmp({31'h0, q[0]}, 32'h1); // settled after wakeup
		poll();
		wb(1'b0, `ADDR_RESULT_HIGH, 8'h00);
		cmp(q, {24'h0, lv[1][9:2]}); // saturated
		// second reset in mid-run
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `ADDR_CONTROL_STATUS, 8'h00);
		cmp({31'h0, power_on_o} | q, 32'h0); // reset clears all
		results();
	end
endmodule
`default_nettype wire

// >>> verilog/adc_clock_div.sv
/*
 * converter clock enable: one-cycle pulse every 2 or 4 system cycles.
 * assumes a single synchronous clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_clock_div (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic run_i,
	input wire logic speed_i,
	// enable out
	output logic tick_o
);
	logic [1:0] count;

	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			count <= 2'h0;
			tick_o <= 1'b0;
		end else begin
			count <= count + 2'h1;
			if (speed_i) begin
				tick_o <= count[0]; // [RULE_09]
			end else begin
				tick_o <= (count == 2'h3); // [RULE_09]
			end
		end
	end
endmodule
`default_nettype wire

// >>> verilog/adc_ctrl_pkg.sv
/*
 * types of the converter control block.
 * assumes nothing beyond the header of constants.
 */
package adc_ctrl_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONVERT = 2'b10
	} conv_state_t;
	typedef logic [3:0] input_select_t;
	typedef logic [9:0] result_t;
endpackage

// >>> verilog/adc_ctrl_regs.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * converter control block. assumes an 8-bit data path in the low byte lane.
 */
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ------------------------------------------------------------------
// offsets
// ------------------------------------------------------------------
`define OFS_CONTROL_STATUS 8'h70
`define OFS_RESULT_HIGH 8'h71
`define OFS_RESULT_LOW 8'h72
`define OFS_POWER_MODE 8'h74
`define ADDR_CONTROL_STATUS 10'h1c0
`define ADDR_RESULT_HIGH 10'h1c4
`define ADDR_RESULT_LOW 10'h1c8
`define ADDR_POWER_MODE 10'h1d0

// ------------------------------------------------------------------
// fields
// ------------------------------------------------------------------
`define BIT_DONE 7
`define BIT_SPEED 6
`define BIT_CONV_ON 5
`define BIT_RESERVED 4
`define CSR_RESET 8'h00
`define CSR_WRITE_MASK 8'h6f

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define SAMPLE_STEPS 4'h2
`define SETTLE_STEPS 8'h40

`endif

// >>> verilog/adc_result_store.sv
/*
 * holds the last converted 10-bit value, registered read ports.
 * assumes the writer presents a whole result in one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_result_store (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// write side
	input wire logic wr_i,
	input wire adc_ctrl_pkg::result_t data_i,
	// read side
	output logic [7:0] high_o,
	output logic [7:0] low_o
);
	import adc_ctrl_pkg::*;

	// not latched: every conversion simply overwrites
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_o <= 8'h00;
			low_o <= 8'h00;
		end else if (wr_i) begin
			high_o <= data_i[9:2]; // [RULE_13] [RULE_07]
			low_o <= {6'h00, data_i[1:0]}; // [RULE_14]
		end
	end
endmodule
`default_nettype wire

// >>> verilog/adc_sequencer_control.sv
/*
 * control and result logic of a 10-bit successive-approximation converter,
 * reached over classic wishbone. assumes an external comparator and input
 * multiplexer driven from the select and trial-code outputs.
 */
// Local design decision: the Wishbone register port.
// Notes on behaviour
// RULE_01: setting converter_on starts continuous back-to-back conversions of selected input.
// RULE_02: end of conversion sets done flag bit 7 and loads both result registers.
// RULE_03: reading the high result register clears the done flag.
// RULE_04: any write to the control/status register clears the done flag; the code clears it only on writes with byte lane 0 selected.
// RULE_05: software 10-bit read: poll flag, read low, then high.
// RULE_06: software 8-bit read: poll flag, read high only.
// RULE_07: results are overwritten by each conversion; software reads them promptly.
// RULE_08: changing input_select mid-conversion aborts, clears flag, restarts on new input.
// RULE_09: speed bit 0 gives clock divided by 4, 1 gives divided by 2.
// RULE_10: clearing converter_on stops the converter and any conversion in progress.
// RULE_11: software writes zero to reserved bit 4.
// RULE_12: input_select value picks analog input of the same index, 0 to 15.
// RULE_13: high result register shows result bits 9:2, read-only.
// RULE_14: low result register shows bits 1:0, upper six bits read zero.
// RULE_15: control/status writable except bit 7, which is read-only.
// RULE_16: processor wait mode does not affect converter operation.
// RULE_17: halt disables converter; software allows settle_time after wakeup.
// RULE_18: inputs above or below references give all-ones or zero results.
// RULE_19: fixed step count per conversion, one bit per step, msb first.
// RULE_20: no interrupt request; completion known only by polling the flag.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_sequencer_control (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// processor power state
	input wire logic wait_mode_i,
	input wire logic halt_mode_i,
	// analog front end
	input wire logic compare_i,
	output adc_ctrl_pkg::input_select_t input_select_o,
	output logic sample_o,
	output logic power_on_o,
	output adc_ctrl_pkg::result_t trial_code_o
);
	import adc_ctrl_pkg::*;

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	logic req;
	logic hit_csr, hit_high, hit_low, hit_pwr, hit_any;
	logic wr_csr, rd_high, lane0;
	logic converter_on, speed, reserved_bit, done;
	input_select_t input_select;
	logic [7:0] high_byte, low_byte;
	logic [7:0] settle_count;
	logic settled;
	conv_state_t state;
	logic [3:0] bit_index;
	result_t code;
	logic tick, run, store;

	function automatic logic addr_is(input logic [9:0] a, input logic [9:0] b);
		addr_is = (a == b);
	endfunction

	assign req = cyc_i && stb_i && !ack_o && !err_o;
	// only byte lane 0 is wired; writes on other lanes are acked and dropped
	assign lane0 = sel_i[0];
	always_comb begin
		hit_csr = 1'b0;
		hit_high = 1'b0;
		hit_low = 1'b0;
		hit_pwr = 1'b0;
		if (addr_is(adr_i, `ADDR_CONTROL_STATUS)) begin
			hit_csr = 1'b1;
		end else if (addr_is(adr_i, `ADDR_RESULT_HIGH)) begin
			hit_high = 1'b1;
		end else if (addr_is(adr_i, `ADDR_RESULT_LOW)) begin
			hit_low = 1'b1;
		end else if (addr_is(adr_i, `ADDR_POWER_MODE)) begin
			hit_pwr = 1'b1;
		end
	end
	assign hit_any = hit_csr || hit_high || hit_low || hit_pwr;
	assign wr_csr = req && we_i && hit_csr && lane0;
	assign rd_high = req && !we_i && hit_high;

	// ------------------------------------------------------------------
	// bus answer
	// ------------------------------------------------------------------
	// one wait state: answer registered, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req && hit_any;
			err_o <= req && !hit_any;
			dat_o <= 32'h0000_0000;
			if (req && !we_i) begin
				if (hit_csr) begin
					dat_o[7:0] <= {done, speed, converter_on, reserved_bit, input_select};
				end else if (hit_high) begin
					dat_o[7:0] <= high_byte; // [RULE_13]
				end else if (hit_low) begin
					dat_o[7:0] <= low_byte; // [RULE_14]
				end else if (hit_pwr) begin
					dat_o[7:0] <= {7'h00, settled};
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// control register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			converter_on <= 1'b0;
			speed <= 1'b0;
			reserved_bit <= 1'b0;
			input_select <= 4'h0;
		end else if (wr_csr) begin
			converter_on <= dat_i[`BIT_CONV_ON]; // [RULE_01] [RULE_10]
			speed <= dat_i[`BIT_SPEED]; // [RULE_09]
			reserved_bit <= dat_i[`BIT_RESERVED];
			input_select <= dat_i[3:0]; // [RULE_12]
		end
	end

	// halt gates the converter off; wait mode is ignored on purpose
	assign run = converter_on && !halt_mode_i; // [RULE_17] [RULE_16]

	// settle counter after halt: status only, results still flow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_count <= 8'h00;
		end else if (!run) begin
			settle_count <= 8'h00;
		end else if (settle_count != `SETTLE_STEPS) begin
			settle_count <= settle_count + 8'h01; // [RULE_17]
		end
	end
	assign settled = (settle_count == `SETTLE_STEPS);

	adc_clock_div u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(run),
		.speed_i(speed),
		.tick_o(tick)
	);

	// ------------------------------------------------------------------
	// approximation sequencer
	// ------------------------------------------------------------------
	// rewriting the same select keeps the running conversion going
	logic restart;
	assign restart = wr_csr && (dat_i[3:0] != input_select); // [RULE_08]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			bit_index <= 4'h0;
			code <= 10'h000;
		end else if (!run) begin
			state <= ST_IDLE; // [RULE_10]
			code <= 10'h000;
		end else if (restart) begin
			state <= ST_SAMPLE; // [RULE_08]
			bit_index <= 4'h0;
			code <= 10'h000;
		end else if (tick) begin
			case (state)
				ST_IDLE: begin
					state <= ST_SAMPLE; // [RULE_01]
					bit_index <= 4'h0;
				end
				ST_SAMPLE: begin
					if (bit_index == `SAMPLE_STEPS - 4'h1) begin
						state <= ST_CONVERT;
						bit_index <= 4'h9;
						code <= 10'h200;
					end else begin
						bit_index <= bit_index + 4'h1;
					end
				end
				ST_CONVERT: begin
					// keep or drop trial bit; saturation falls out of the search
					code[bit_index] <= compare_i; // [RULE_19] [RULE_18]
					if (bit_index == 4'h0) begin
						state <= ST_SAMPLE; // [RULE_01]
					end else begin
						code[bit_index - 4'h1] <= 1'b1;
						bit_index <= bit_index - 4'h1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// the live decision feeds the last bit, so storing costs no extra tick
	assign store = run && !restart && tick && (state == ST_CONVERT) && (bit_index == 4'h0);

	adc_result_store u_store (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(store),
		.data_i({code[9:1], compare_i}),
		.high_o(high_byte),
		.low_o(low_byte)
	);

	// ------------------------------------------------------------------
	// done flag
	// ------------------------------------------------------------------
	// set wins over any clear in the same cycle; no interrupt is raised
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done <= 1'b0;
		end else if (store) begin
			done <= 1'b1; // [RULE_02] [RULE_20]
		end else if (wr_csr || rd_high) begin
			done <= 1'b0; // [RULE_03] [RULE_04] [RULE_15]
		end
	end

	// ------------------------------------------------------------------
	// front-end outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_select_o <= 4'h0;
			sample_o <= 1'b0;
			power_on_o <= 1'b0;
			trial_code_o <= 10'h000;
		end else begin
			input_select_o <= input_select; // [RULE_12]
			sample_o <= run && (state == ST_SAMPLE);
			power_on_o <= run;
			trial_code_o <= code;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	// bus checks look one cycle after a request is taken
	a_done_on_store: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_02]
		store |=> done) else $error("done flag not set after conversion");
	a_high_read_clears: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
		rd_high && !store |=> !done) else $error("high read did not clear done");
	a_write_clears: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
		wr_csr && !store |=> !done) else $error("control write did not clear done");
	a_off_idles: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
		!run |=> state == ST_IDLE) else $error("sequencer ran while off");
	a_select_restart: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
		run && restart |=> state == ST_SAMPLE && bit_index == 4'h0)
		else $error("select change did not restart");
	a_result_layout: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_13]
		store |=> high_byte == $past(code[9:2]) && low_byte[7:2] == 6'h00)
		else $error("result bytes misplaced");
	a_low_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_14]
		low_byte[7:2] == 6'h00) else $error("low reserved bits set");
	a_fast_tick: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
		tick && speed && run && $past(run) && $past(speed) |=> !tick ##1 (tick || !run || !speed))
		else $error("divide by two broken");
	a_wait_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_16]
		converter_on && !halt_mode_i |=> power_on_o) else $error("wait mode stopped converter");
	a_halt_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_17]
		halt_mode_i |=> !power_on_o) else $error("converter on in halt");
	a_csr_fields: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_15]
		wr_csr |=> {speed, converter_on, reserved_bit, input_select} == $past(dat_i[6:0]))
		else $error("control fields not written");
	a_select_out: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_12]
		wr_csr |=> ##1 input_select_o == $past(dat_i[3:0], 2))
		else $error("select output does not follow the register");
	a_back_to_back: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
		store |=> state == ST_SAMPLE) else $error("conversions not back to back");
	a_step_down: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_19]
		run && !restart && tick && state == ST_CONVERT && bit_index != 4'h0
		|=> state == ST_CONVERT && bit_index == $past(bit_index) - 4'h1)
		else $error("bit step skipped");
	a_high_data: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_13]
		rd_high |=> dat_o == {24'h000000, $past(high_byte)}) else $error("high read data wrong");
	a_low_data: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_14]
		req && !we_i && hit_low |=> dat_o[31:2] == 30'h0) else $error("low read upper bits set");
endmodule
`default_nettype wire
